// ===== shared/ifb_cfg.svh
// Constants for the flash access and code banking block.
// Assumes an 8-bit special-function register bus on the CPU core clock.
`ifndef IFB_CFG_SVH
`define IFB_CFG_SVH
`define IFB_ADDR_BANK_CTL   8'hab
`define IFB_ADDR_ISP_LOW    8'hac
`define IFB_ADDR_ISP_HIGH   8'had
`define IFB_ADDR_ISP_DATA   8'hae
`define IFB_ADDR_ISP_OP     8'haf
`define IFB_ADDR_ISP_MODE   8'h9f
`define IFB_BIT_ISP_EN      0
`define IFB_BIT_RESTART     1
`define IFB_BIT_BANKING     3
`define IFB_BIT_BANK        7
`define IFB_BIT_ARRAY       6
`define IFB_BIT_OE_N        5
`define IFB_BIT_CE_N        4
`define IFB_RST_BANK_CTL    8'h07
`define IFB_RST_ISP_OP      8'h30
`define IFB_RST_BYTE        8'h00
`define IFB_OP_ERASE        4'h2
`define IFB_OP_PROGRAM      4'h1
`define IFB_OP_READ         4'h0
`define IFB_ERASE_CYCLES    16'h00ff
`define IFB_PROG_CYCLES     16'h000f
`define IFB_READ_CYCLES     16'h0002
`define IFB_SRAM_WORDS      16
`endif

// ===== shared/ifb_pkg.sv
// Types for the flash access and code banking block.
// Assumes ifb_cfg.svh holds the numeric constants.
package ifb_pkg;
    typedef enum logic [1:0] {
        IFB_IDLE  = 2'b00,
        IFB_RUN   = 2'b01,
        IFB_DONE  = 2'b10
    } ifb_state_t;
    typedef enum logic [1:0] {
        IFB_TGT_APP0   = 2'b00,
        IFB_TGT_APP1   = 2'b01,
        IFB_TGT_LOADER = 2'b10
    } ifb_target_t;
endpackage

// ===== logic/ifb_shadow_mem.sv
// Small register file that holds the last bytes read back from flash, by low address.
// Assumes one clock; read data come out of a register one cycle after the request.
module ifb_shadow_mem (
    // Clock
    input  wire logic       clk_in,
    // Write side
    input  wire logic       wr_en_in,
    input  wire logic [3:0] wr_addr_in,
    input  wire logic [7:0] wr_data_in,
    // Read side
    input  wire logic [3:0] rd_addr_in,
    output logic      [7:0] rd_data_out
);
    logic [7:0] mem [0:15];
    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
        rd_data_out <= mem[rd_addr_in];
    end
endmodule

// ===== logic/ifb_flash_access.sv
// ISP flash sequencer and code banking selector.
// Assumes an 8-bit SFR bus on the CPU clock, flash arrays with a done strobe,
// and port 1 pins arriving asynchronously from the pads.
`include "ifb_cfg.svh"
module ifb_flash_access (
    // Clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 rst_in,
    // SFR bus
    input  wire logic [7:0]           sfr_addr_in,
    input  wire logic                 sfr_wr_in,
    input  wire logic                 sfr_rd_in,
    input  wire logic [7:0]           sfr_wdata_in,
    output logic      [7:0]           sfr_rdata_out,
    // CPU power control
    input  wire logic                 idle_control_bit_in,
    output logic                      cpu_idle_out,
    output logic                      cpu_restart_out,
    output logic                      restart_array_select_out,
    // Flash arrays
    output logic                      flash_start_out,
    output ifb_pkg::ifb_target_t      flash_target_out,
    output logic [3:0]                flash_op_out,
    output logic [15:0]               flash_addr_out,
    output logic [7:0]                flash_wdata_out,
    output logic                      flash_output_enable_n_out,
    output logic                      flash_chip_enable_n_out,
    input  wire logic [7:0]           flash_rdata_in,
    input  wire logic                 flash_done_in,
    // Code banking and busy status
    input  wire logic [7:0]           port1_pins_in,
    output logic                      code_fetch_bank_out,
    output logic                      busy_out
);
    import ifb_pkg::*;

    logic [7:0]  code_bank_control;
    logic [7:0]  isp_addr_low;
    logic [7:0]  isp_addr_high;
    logic [7:0]  isp_data_buffer;
    logic [7:0]  isp_operation_control;
    logic        isp_mode_enable;
    logic        restart_array_select;
    ifb_state_t  state;
    logic [15:0] timer;
    logic [7:0]  next_code_bank_control;
    logic [7:0]  next_isp_addr_low;
    logic [7:0]  next_isp_addr_high;
    logic [7:0]  next_isp_data_buffer;
    logic [7:0]  next_isp_operation_control;
    logic        next_isp_mode_enable;
    logic        next_restart_array_select;
    ifb_state_t  next_state;
    logic [15:0] next_timer;
    logic [7:0]  p1_meta;
    logic [7:0]  p1_sync;
    logic        next_cpu_idle;
    logic        next_restart;
    logic        next_start;
    logic        next_bank;
    logic [7:0]  next_rdata;
    logic [3:0]  ctrl_code;
    ifb_target_t target;
    logic [15:0] op_limit;
    logic [7:0]  mem_rd;

    assign ctrl_code = isp_operation_control[3:0];

    // Loader when the array bit is set, else the bank bit picks the app array
    always_comb begin
        if (isp_operation_control[`IFB_BIT_ARRAY]) begin
            target = IFB_TGT_LOADER;
        end else if (isp_operation_control[`IFB_BIT_BANK]) begin
            target = IFB_TGT_APP1;
        end else begin
            target = IFB_TGT_APP0;
        end
    end

    // Fallback duration when the array gives no done strobe
    always_comb begin
        case (ctrl_code)
            `IFB_OP_ERASE:   op_limit = `IFB_ERASE_CYCLES;
            `IFB_OP_PROGRAM: op_limit = `IFB_PROG_CYCLES;
            default:         op_limit = `IFB_READ_CYCLES;
        endcase
    end

    ifb_shadow_mem u_shadow (
        .clk_in      (clk_in),
        .wr_en_in    (state == IFB_RUN && flash_done_in && ctrl_code == `IFB_OP_READ),
        .wr_addr_in  (isp_addr_low[3:0]),
        .wr_data_in  (flash_rdata_in),
        .rd_addr_in  (isp_addr_low[3:0]),
        .rd_data_out (mem_rd)
    );

    // Register writes and the sequencer
    always_comb begin
        next_code_bank_control     = code_bank_control;
        next_isp_addr_low          = isp_addr_low;
        next_isp_addr_high         = isp_addr_high;
        next_isp_data_buffer       = isp_data_buffer;
        next_isp_operation_control = isp_operation_control;
        next_isp_mode_enable       = isp_mode_enable;
        next_restart_array_select  = restart_array_select;
        next_state                 = state;
        next_timer                 = timer;
        next_start                 = 1'b0;
        next_restart               = 1'b0;
        if (sfr_wr_in) begin
            if (sfr_addr_in == `IFB_ADDR_BANK_CTL) begin
                next_code_bank_control = {4'h0, sfr_wdata_in[3:0]};
            end else if (sfr_addr_in == `IFB_ADDR_ISP_LOW) begin
                next_isp_addr_low = sfr_wdata_in;
            end else if (sfr_addr_in == `IFB_ADDR_ISP_HIGH) begin
                next_isp_addr_high = sfr_wdata_in;
            end else if (sfr_addr_in == `IFB_ADDR_ISP_DATA) begin
                next_isp_data_buffer = sfr_wdata_in;
            end else if (sfr_addr_in == `IFB_ADDR_ISP_OP) begin
                next_isp_operation_control = sfr_wdata_in;
            end else if (sfr_addr_in == `IFB_ADDR_ISP_MODE) begin
                next_isp_mode_enable      = sfr_wdata_in[`IFB_BIT_ISP_EN];
                next_restart_array_select = sfr_wdata_in[`IFB_BIT_RESTART];
            end
        end
        case (state)
            IFB_IDLE: begin
                // Idle request in ISP mode launches the action
                if (isp_mode_enable && idle_control_bit_in) begin
                    next_state = IFB_RUN;
                    next_timer = 16'h0000;
                    next_start = 1'b1;
                end
            end
            IFB_RUN: begin
                next_timer = timer + 16'h0001;
                if (flash_done_in || timer >= op_limit) begin
                    if (ctrl_code == `IFB_OP_READ) begin
                        next_isp_data_buffer = flash_rdata_in;
                    end
                    next_state = IFB_DONE;
                end
            end
            IFB_DONE: begin
                next_restart = 1'b1;
                next_state   = IFB_IDLE;
            end
            default: begin
                next_state = IFB_IDLE;
            end
        endcase
    end

    // CPU idle: forced during an action, else follows idle bit outside ISP mode
    always_comb begin
        if (state != IFB_IDLE) begin
            next_cpu_idle = (next_state != IFB_IDLE);
        end else if (isp_mode_enable) begin
            next_cpu_idle = next_state == IFB_RUN;
        end else begin
            next_cpu_idle = idle_control_bit_in;
        end
        // Banking: selected port 1 pin is address line 16
        next_bank = code_bank_control[`IFB_BIT_BANKING] &&
                    p1_sync[code_bank_control[2:0]];
        if (sfr_rd_in && sfr_addr_in == `IFB_ADDR_BANK_CTL) begin
            next_rdata = code_bank_control;
        end else if (sfr_rd_in && sfr_addr_in == `IFB_ADDR_ISP_LOW) begin
            next_rdata = isp_addr_low;
        end else if (sfr_rd_in && sfr_addr_in == `IFB_ADDR_ISP_HIGH) begin
            next_rdata = isp_addr_high;
        end else if (sfr_rd_in && sfr_addr_in == `IFB_ADDR_ISP_DATA) begin
            next_rdata = isp_data_buffer;
        end else if (sfr_rd_in && sfr_addr_in == `IFB_ADDR_ISP_OP) begin
            next_rdata = isp_operation_control;
        end else if (sfr_rd_in && sfr_addr_in == `IFB_ADDR_ISP_MODE) begin
            next_rdata = {7'h00, isp_mode_enable};
        end else begin
            next_rdata = 8'h00;
        end
    end

    always_ff @(posedge clk_in) begin
        p1_meta <= port1_pins_in;
        p1_sync <= p1_meta;
        if (rst_in) begin
            code_bank_control         <= `IFB_RST_BANK_CTL;
            isp_addr_low              <= `IFB_RST_BYTE;
            isp_addr_high             <= `IFB_RST_BYTE;
            isp_data_buffer           <= `IFB_RST_BYTE;
            isp_operation_control     <= `IFB_RST_ISP_OP;
            isp_mode_enable           <= 1'b0;
            restart_array_select      <= 1'b0;
            state                     <= IFB_IDLE;
            timer                     <= 16'h0000;
            sfr_rdata_out             <= 8'h00;
            cpu_idle_out              <= 1'b0;
            cpu_restart_out           <= 1'b0;
            restart_array_select_out  <= 1'b0;
            flash_start_out           <= 1'b0;
            flash_target_out          <= IFB_TGT_APP0;
            flash_op_out              <= `IFB_OP_READ;
            flash_addr_out            <= 16'h0000;
            flash_wdata_out           <= 8'h00;
            flash_output_enable_n_out <= 1'b1;
            flash_chip_enable_n_out   <= 1'b1;
            code_fetch_bank_out       <= 1'b0;
            busy_out                  <= 1'b0;
        end else begin
            code_bank_control         <= next_code_bank_control;
            isp_addr_low              <= next_isp_addr_low;
            isp_addr_high             <= next_isp_addr_high;
            isp_data_buffer           <= next_isp_data_buffer;
            isp_operation_control     <= next_isp_operation_control;
            isp_mode_enable           <= next_isp_mode_enable;
            restart_array_select      <= next_restart_array_select;
            state                     <= next_state;
            timer                     <= next_timer;
            sfr_rdata_out             <= next_rdata;
            cpu_idle_out              <= next_cpu_idle;
            cpu_restart_out           <= next_restart;
            restart_array_select_out  <= restart_array_select;
            flash_start_out           <= next_start;
            flash_target_out          <= target;
            flash_op_out              <= ctrl_code;
            flash_addr_out            <= {isp_addr_high, isp_addr_low};
            flash_wdata_out           <= isp_data_buffer;
            flash_output_enable_n_out <= isp_operation_control[`IFB_BIT_OE_N];
            flash_chip_enable_n_out   <= isp_operation_control[`IFB_BIT_CE_N];
            code_fetch_bank_out       <= next_bank;
            busy_out                  <= next_state != IFB_IDLE;
        end
    end

    logic unused_mem;
    assign unused_mem = ^mem_rd;
endmodule

// ===== verification/ifb_flash_access_assertions.sv
// Port-level property checks for the flash sequencer and code banking block.
// Assumes one clock, clk_in, and rst_in as a synchronous active-high reset.
module ifb_flash_access_checker (
    input wire logic                 clk_in,
    input wire logic                 rst_in,
    input wire logic [7:0]           sfr_addr_in,
    input wire logic                 sfr_wr_in,
    input wire logic                 sfr_rd_in,
    input wire logic [7:0]           sfr_wdata_in,
    input wire logic [7:0]           sfr_rdata_out,
    input wire logic                 cpu_idle_out,
    input wire logic                 cpu_restart_out,
    input wire logic                 flash_start_out,
    input wire ifb_pkg::ifb_target_t flash_target_out,
    input wire logic                 flash_done_in,
    input wire logic                 code_fetch_bank_out,
    input wire logic                 busy_out
);
    timeunit 1ns;
    timeprecision 1ns;
    import ifb_pkg::*;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    start_pulse_a: assert property (flash_start_out |=> !flash_start_out)
        else $error("start strobe longer than one cycle");
    start_idle_a: assert property (flash_start_out |-> cpu_idle_out && busy_out)
        else $error("action started without holding the cpu idle");
    restart_after_done_a: assert property (busy_out && flash_done_in |-> ##2 cpu_restart_out)
        else $error("no restart two cycles after done");
    restart_frees_a: assert property (cpu_restart_out |-> !cpu_idle_out)
        else $error("cpu still idle at restart");
    busy_no_start_a: assert property (busy_out |=> !flash_start_out)
        else $error("new action launched while busy");
    busy_bound_a: assert property ($rose(busy_out) |-> ##[1:300] !busy_out)
        else $error("action never ended");
    target_legal_a: assert property (flash_start_out |-> flash_target_out != 2'b11)
        else $error("illegal flash target");
    rdata_quiet_a: assert property (!sfr_rd_in |=> sfr_rdata_out == 8'h00)
        else $error("read data without a read");
    bank_off_a: assert property (sfr_wr_in && sfr_addr_in == 8'hab && !sfr_wdata_in[3] ##1
        !(sfr_wr_in && sfr_addr_in == 8'hab) [*3] |-> !code_fetch_bank_out)
        else $error("bank line high with banking off");
    cover property (flash_start_out);
    cover property (cpu_restart_out);
    cover property (code_fetch_bank_out);
endmodule

// ===== verification/ifb_flash_model.sv
// Behavioural loader and application flash arrays behind the sequencer.
// Assumes one clock; erased bytes read as all ones; read answers come two cycles after the start strobe.
module ifb_flash_model (
    input  wire logic        clk_in,
    input  wire logic        start_in,
    input  wire logic [1:0]  target_in,
    input  wire logic [3:0]  op_in,
    input  wire logic [15:0] addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        slow_in,
    output logic      [7:0]  rdata_out,
    output logic             done_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [3][logic [15:0]];
    logic [7:0] rd = 8'h00;
    int         wait_n = -1;
    initial begin
        rdata_out = 8'h00;
        done_out = 1'b0;
    end
    always @(posedge clk_in) begin
        done_out <= 1'b0;
        rdata_out <= ~rdata_out;    // Released data lines never hold a value
        if (wait_n == 0) begin
            done_out <= 1'b1;
            rdata_out <= rd;
        end
        if (wait_n >= 0)
            wait_n <= wait_n - 1;
        if (start_in) begin
            wait_n <= (slow_in && op_in != 4'h0) ? 8 : 0;
            if (op_in == 4'h2)
                mem[target_in].delete();
            else if (op_in == 4'h1)
                mem[target_in][addr_in] = wdata_in;
            else
                rd <= mem[target_in].exists(addr_in) ? mem[target_in][addr_in] : 8'hff;
        end
    end
endmodule

// ===== verification/isp_flash_access_and_code_banking_bench.sv
// Self-checking bench for the flash sequencer and code banking block.
// Assumes ifb_cfg.svh on the include path and the flash model alongside.
`include "ifb_cfg.svh"
module isp_flash_access_and_code_banking_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import ifb_pkg::*;
    logic        clk_in = 1'b0, rst_in = 1'b1, sfr_wr_in = 1'b0, sfr_rd_in = 1'b0;
    logic        idle_control_bit_in = 1'b0, slow = 1'b0;
    logic [7:0]  sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, port1_pins_in = 8'h00;
    logic [7:0]  sfr_rdata_out, flash_wdata_out, flash_rdata_in, base;
    logic        cpu_idle_out, cpu_restart_out, restart_array_select_out, flash_start_out;
    logic        flash_output_enable_n_out, flash_chip_enable_n_out, flash_done_in;
    logic        code_fetch_bank_out, busy_out;
    ifb_target_t flash_target_out;
    logic [3:0]  flash_op_out;
    logic [15:0] flash_addr_out;
    int          errors = 0, compares = 0, cycles = 0;
    ifb_flash_access dut (
        .clk_in                    (clk_in),
        .rst_in                    (rst_in),
        .sfr_addr_in               (sfr_addr_in),
        .sfr_wr_in                 (sfr_wr_in),
        .sfr_rd_in                 (sfr_rd_in),
        .sfr_wdata_in              (sfr_wdata_in),
        .sfr_rdata_out             (sfr_rdata_out),
        .idle_control_bit_in       (idle_control_bit_in),
        .cpu_idle_out              (cpu_idle_out),
        .cpu_restart_out           (cpu_restart_out),
        .restart_array_select_out  (restart_array_select_out),
        .flash_start_out           (flash_start_out),
        .flash_target_out          (flash_target_out),
        .flash_op_out              (flash_op_out),
        .flash_addr_out            (flash_addr_out),
        .flash_wdata_out           (flash_wdata_out),
        .flash_output_enable_n_out (flash_output_enable_n_out),
        .flash_chip_enable_n_out   (flash_chip_enable_n_out),
        .flash_rdata_in            (flash_rdata_in),
        .flash_done_in             (flash_done_in),
        .port1_pins_in             (port1_pins_in),
        .code_fetch_bank_out       (code_fetch_bank_out),
        .busy_out                  (busy_out)
    );
    ifb_flash_model flash (.clk_in(clk_in), .start_in(flash_start_out),
        .target_in(flash_target_out), .op_in(flash_op_out), .addr_in(flash_addr_out),
        .wdata_in(flash_wdata_out), .slow_in(slow), .rdata_out(flash_rdata_in),
        .done_out(flash_done_in));
    initial forever #20 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            test_done();
        end
    end
    task automatic test_done();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        sfr_addr_in <= a;
        sfr_wdata_in <= d;
        sfr_wr_in <= 1'b1;
        @(posedge clk_in);
        sfr_wr_in <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic reg_is(logic [7:0] a, logic [7:0] e);
        sfr_addr_in <= a;
        sfr_rd_in <= 1'b1;
        @(posedge clk_in);
        sfr_rd_in <= 1'b0;
        #1 check($sformatf("sfr %h", a), sfr_rdata_out, e);
        @(posedge clk_in);
    endtask
    task automatic act(logic [7:0] op, logic [7:0] mode, logic [15:0] a, logic [7:0] d);
        logic [1:0] t;
        int         n;
        t = op[6] ? 2'h2 : {1'b0, op[7]};
        wr(8'h9f, mode);
        wr(8'hac, a[7:0]);
        wr(8'had, a[15:8]);
        wr(8'hae, d);
        wr(8'haf, op);
        idle_control_bit_in <= 1'b1;
        @(posedge clk_in);
        idle_control_bit_in <= 1'b0;
        #1 check("start", {flash_start_out, cpu_idle_out, busy_out}, 3'b111);
        check("target", flash_target_out, t);
        check("op", {flash_output_enable_n_out, flash_chip_enable_n_out, flash_op_out},
              {op[5:4], op[3:0]});
        check("addr", {flash_addr_out, flash_wdata_out}, {a, d});
        n = 0;
        while (cpu_restart_out !== 1'b1 && n < 400) begin
            @(posedge clk_in);
            #1 n++;
        end
        check("restart", {cpu_restart_out, restart_array_select_out}, {1'b1, mode[1]});
        @(posedge clk_in);
    endtask
    initial begin
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        #1 check("idle ce oe", {flash_chip_enable_n_out, flash_output_enable_n_out}, 2'b11);
        @(posedge clk_in);
        reg_is(8'hab, `IFB_RST_BANK_CTL);
        reg_is(8'haf, `IFB_RST_ISP_OP);
        for (int i = 0; i < 3; i++) reg_is(8'hac + 8'(i), 8'h00);
        $display("test reset done");
        for (int s = 0; s < 8; s++) begin
            wr(8'hab, 8'h08 | 8'(s));
            port1_pins_in <= 8'h01 << s;
            repeat (4) @(posedge clk_in);
            #1 check("bank high", code_fetch_bank_out, 1'b1);
            @(posedge clk_in);
            port1_pins_in <= ~(8'h01 << s);
            repeat (4) @(posedge clk_in);
            #1 check("bank low", code_fetch_bank_out, 1'b0);
            @(posedge clk_in);
        end
        port1_pins_in <= 8'hff;
        wr(8'hab, 8'h07);
        repeat (4) @(posedge clk_in);
        #1 check("bank off", code_fetch_bank_out, 1'b0);
        @(posedge clk_in);
        $display("test banking done");
        for (int t = 0; t < 3; t++) begin
            base = (t == 2) ? 8'h40 : (t == 1) ? 8'h80 : 8'h00;
            slow = t[0];
            act(base | 8'h22, t == 2 ? 8'h03 : 8'h01, 16'hf0e1, 8'h00);
            act(base | 8'h21, t == 2 ? 8'h03 : 8'h01, 16'hf0e1, 8'h5a + 8'(t));
            act(base | 8'h00, t == 2 ? 8'h03 : 8'h01, 16'hf0e1, 8'h00);
            reg_is(8'hae, 8'h5a + 8'(t));
            act(base | 8'h00, 8'h01, 16'hf0e2, 8'h00);
            reg_is(8'hae, 8'hff);
        end
        $display("test isp actions done");
        wr(8'h9f, 8'h00);
        idle_control_bit_in <= 1'b1;
        @(posedge clk_in);
        #1 check("normal idle", {cpu_idle_out, flash_start_out}, 2'b10);
        @(posedge clk_in);
        idle_control_bit_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        #1 check("normal wake", {cpu_idle_out, busy_out}, 2'b00);
        $display("test normal mode done");
        test_done();
    end
endmodule
bind ifb_flash_access ifb_flash_access_checker chk (
    .clk_in              (clk_in),
    .rst_in              (rst_in),
    .sfr_addr_in         (sfr_addr_in),
    .sfr_wr_in           (sfr_wr_in),
    .sfr_rd_in           (sfr_rd_in),
    .sfr_wdata_in        (sfr_wdata_in),
    .sfr_rdata_out       (sfr_rdata_out),
    .cpu_idle_out        (cpu_idle_out),
    .cpu_restart_out     (cpu_restart_out),
    .flash_start_out     (flash_start_out),
    .flash_target_out    (flash_target_out),
    .flash_done_in       (flash_done_in),
    .code_fetch_bank_out (code_fetch_bank_out),
    .busy_out            (busy_out)
);
